// ===== src/scsr_regs.sv
`timescale 1ns/10ps
// Function
// - Reserved and sequence bits read zero
// - Three ordered writes reset digital logic
// - Other bits ignored; zero bits abort
// - Control reads zero after any reset
// - Clear-error clears transients, reads zero
// - Data held off until error cleared
// - Reset flag clears only after init
// - Bypass removes and freezes the filter
// - Self-test both axes, direction, cleared
// - Self-test state in every result
// - Direction polarity, Y inversion in self-test
// - Offset correction ignores Y inversion
// - Temperature read-only signed, rises with heat
// - Data error set by parity, sticky
// - Oscillator fault forces data output high while selected, not in test mode
// - Init flag from reset until done
// - Temperature fault cleared when gone
// - Filter-present status follows bypass and self-test
// - Offset flags, blanked after reset
// - Reset flag set by init, cleared
// - Free 8-bit counter every 8 us
// - Only control register accepts writes
module scsr_regs
  import scsr_pkg::*;
#(
  parameter longint OFFSET_BLANK = OFFSET_BLANK_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_request_error,
  input wire logic init_done,
  input wire logic test_mode,
  input wire logic parity_fault,
  input wire logic fuse_parity_fault,
  input wire logic marginal_fuse,
  input wire logic osc_mismatch,
  input wire logic temp_limit,
  input wire logic offset_limit_x,
  input wire logic offset_limit_y,
  input wire logic [7:0] temp_sample,
  input wire logic chip_select_n,
  output logic osc_force_dout_high,
  output logic filter_bypass,
  output logic filter_freeze,
  output logic self_test_enable,
  output logic self_test_direction,
  output logic y_invert_active,
  output logic accel_data_allowed,
  output logic soft_reset
);
  import scsr_pkg::*;

  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic err_reg;
  logic err_next;
  logic fuse_bad_reg;
  logic fuse_bad_next;
  logic [31:0] blank_reg;
  logic [31:0] blank_next;
  logic [7:0] temp_reg;
  logic [7:0] temp_next;
  logic [1:0] osc_sync_reg;
  logic [1:0] osc_sync_next;
  logic ctl_write;
  logic clear_err;
  logic blanking;
  logic [7:0] count_value;
  logic [7:0] stat_view;

  ////////////////////////////////////////////////////////////////
  // Helpers shared by several processes

  // Only one address takes writes; everything else is refused
  function automatic logic is_ctl_addr(input logic [4:0] addr);
    return (addr == ADDR_DEVICE_CONTROL);
  endfunction

  // Control bits that can ever be kept or seen
  function automatic logic [7:0] ctl_visible(input logic [7:0] data);
    return data & CTL_READ_MASK;
  endfunction

  // Filter leaves the chain for bypass and for self-test alike
  function automatic logic filter_out(input logic [7:0] ctl);
    return ctl[CTL_FILTER_BYPASS] | ctl[CTL_SELF_TEST_ENABLE];
  endfunction

  // Flags that arm the error latch; init and reset flags do not
  function automatic logic error_flags(input logic [7:0] stat);
    return stat[STAT_INTERNAL_DATA_ERROR] | stat[STAT_OSCILLATOR_FAULT] | stat[STAT_TEMPERATURE_FAULT]
      | stat[STAT_OFFSET_Y] | stat[STAT_OFFSET_X];
  endfunction

  ////////////////////////////////////////////////////////////////
  // Write decode
  // writes only to control
  assign ctl_write = reg_write && is_ctl_addr(reg_addr);
  // Combinational so the framing can answer within the same frame
  assign reg_request_error = reg_write && !is_ctl_addr(reg_addr);
  assign clear_err = ctl_write && reg_wdata[CTL_CLEAR_ERROR];
  // Offset faults are ignored while blanking runs
  assign blanking = (blank_reg != 32'h0000_0000);

  // Tracker sees the raw sequence bits of every control write
  scsr_reset_seq u_reset_seq
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ctl_write(ctl_write),
    .seq_upper(reg_wdata[CTL_RESET_SEQ_UPPER]),
    .seq_lower(reg_wdata[CTL_RESET_SEQ_LOWER]),
    .soft_reset(soft_reset)
  );

  scsr_tick_counter u_tick_counter
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .soft_reset(soft_reset),
    .count_value(count_value)
  );

  ////////////////////////////////////////////////////////////////
  // Control register: only bypass, inversion and self-test bits are kept
  always_comb
  begin
    ctl_next = ctl_reg;
    if (soft_reset)
      ctl_next = CTL_RESET_VALUE;
    else if (ctl_write)
      ctl_next = ctl_visible(reg_wdata);
  end

  ////////////////////////////////////////////////////////////////
  // Status flags; set terms are ORed last so an event beats a clear
  always_comb
  begin
    stat_next = stat_reg;
    // Fuse-array parity damage is remembered for good
    fuse_bad_next = fuse_bad_reg | fuse_parity_fault;
    // Offset blanking counts down, then rests at zero
    blank_next = blanking ? blank_reg - 32'h0000_0001 : blank_reg;
    if (soft_reset)
    begin
      // Fuse-array parity damage survives the soft reset
      stat_next = 8'h00;
      stat_next[STAT_INTERNAL_DATA_ERROR] = fuse_bad_reg && !test_mode;
      stat_next[STAT_DEVICE_RESET_FLAG] = 1'b1;
      stat_next[STAT_INIT_IN_PROGRESS] = 1'b1;
      blank_next = 32'(OFFSET_BLANK);
    end
    else
    begin
      if (init_done)
        stat_next[STAT_INIT_IN_PROGRESS] = 1'b0;
      if (clear_err && !stat_reg[STAT_INIT_IN_PROGRESS])
        stat_next[STAT_DEVICE_RESET_FLAG] = 1'b0;
      if (clear_err && !temp_limit)
        stat_next[STAT_TEMPERATURE_FAULT] = 1'b0;
      if (clear_err)
      begin
        stat_next[STAT_OFFSET_X] = 1'b0;
        stat_next[STAT_OFFSET_Y] = 1'b0;
      end
      // clear only once the clocks agree
      if (clear_err && !osc_sync_reg[1])
        stat_next[STAT_OSCILLATOR_FAULT] = 1'b0;
      if (!test_mode && (parity_fault || fuse_parity_fault || marginal_fuse || fuse_bad_reg))
        stat_next[STAT_INTERNAL_DATA_ERROR] = 1'b1;
      if (osc_sync_reg[1])
        stat_next[STAT_OSCILLATOR_FAULT] = 1'b1;
      if (temp_limit)
        stat_next[STAT_TEMPERATURE_FAULT] = 1'b1;
      if (!blanking && offset_limit_x)
        stat_next[STAT_OFFSET_X] = 1'b1;
      if (!blanking && offset_limit_y)
        stat_next[STAT_OFFSET_Y] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Error latch gating acceleration data
  always_comb
  begin
    err_next = err_reg;
    if (soft_reset || clear_err)
      err_next = 1'b0;
    // hold off data
    // Judged on the flags as they stand after this cycle's clear;
    // the old flags would re-arm the latch and need a second clear
    if (!soft_reset && error_flags(stat_next))
      err_next = 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // Oscillator compare result comes from another domain: two stages
  assign osc_sync_next = {osc_sync_reg[0], osc_mismatch};
  assign temp_next = temp_sample;

  // Live filter-present bit folded into the status view
  always_comb
  begin
    stat_view = stat_reg;
    stat_view[STAT_FILTER_PRESENT] = !filter_out(ctl_reg);
  end

  // Read data mux, registered
  always_comb
  begin
    // Read data holds between reads
    rdata_next = rdata_reg;
    if (reg_read)
    begin
      unique case (reg_addr)
        ADDR_DEVICE_CONTROL: rdata_next = ctl_visible(ctl_reg);
        ADDR_TEMPERATURE_VALUE: rdata_next = temp_reg;
        ADDR_DEVICE_STATUS: rdata_next = stat_view;
        ADDR_TICK_COUNTER: rdata_next = count_value;
        // Unmapped addresses read zero
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctl_reg <= CTL_RESET_VALUE;
      // Power-up looks like a finished soft reset: init running
      stat_reg <= STAT_RESET_VALUE;
      rdata_reg <= 8'h00;
      err_reg <= 1'b0;
      fuse_bad_reg <= 1'b0;
      blank_reg <= 32'(OFFSET_BLANK);
      temp_reg <= 8'h00;
      osc_sync_reg <= 2'b00;
    end
    else
    begin
      ctl_reg <= ctl_next;
      stat_reg <= stat_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      fuse_bad_reg <= fuse_bad_next;
      blank_reg <= blank_next;
      temp_reg <= temp_next;
      osc_sync_reg <= osc_sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs to the datapath
  assign reg_rdata = rdata_reg;
  assign filter_bypass = filter_out(ctl_reg);
  assign filter_freeze = filter_bypass;
  assign self_test_enable = ctl_reg[CTL_SELF_TEST_ENABLE];
  assign self_test_direction = ctl_reg[CTL_SELF_TEST_DIRECTION];
  // inversion only in self-test; offset path untouched
  assign y_invert_active = ctl_reg[CTL_Y_INVERSION] & ctl_reg[CTL_SELF_TEST_ENABLE];
  // data released after clear
  // Init keeps data back as well, giving a no-data answer
  assign accel_data_allowed = !err_reg && !stat_reg[STAT_INIT_IN_PROGRESS];
  // Limitation: chip select is taken as already synchronised
  // force output high
  assign osc_force_dout_high = stat_reg[STAT_OSCILLATOR_FAULT] && !test_mode && !chip_select_n;
endmodule

// ===== src/scsr_pkg.sv
package scsr_pkg;
  // Register addresses on the five-bit register address field
  localparam logic [4:0] ADDR_DEVICE_CONTROL = 5'h0e;
  localparam logic [4:0] ADDR_TEMPERATURE_VALUE = 5'h0f;
  localparam logic [4:0] ADDR_DEVICE_STATUS = 5'h10;
  localparam logic [4:0] ADDR_TICK_COUNTER = 5'h11;
  // Control register field positions
  localparam int CTL_RESET_SEQ_UPPER = 7;
  localparam int CTL_RESET_SEQ_LOWER = 6;
  localparam int CTL_CLEAR_ERROR = 5;
  localparam int CTL_RESERVED = 4;
  localparam int CTL_FILTER_BYPASS = 3;
  localparam int CTL_Y_INVERSION = 2;
  localparam int CTL_SELF_TEST_DIRECTION = 1;
  localparam int CTL_SELF_TEST_ENABLE = 0;
  // Bits that may read back as one
  localparam logic [7:0] CTL_READ_MASK = 8'h0f;
  localparam logic [7:0] CTL_RESET_VALUE = 8'h00;
  // Status register field positions
  localparam int STAT_INTERNAL_DATA_ERROR = 7;
  localparam int STAT_OSCILLATOR_FAULT = 6;
  localparam int STAT_INIT_IN_PROGRESS = 5;
  localparam int STAT_TEMPERATURE_FAULT = 4;
  localparam int STAT_FILTER_PRESENT = 3;
  localparam int STAT_OFFSET_Y = 2;
  localparam int STAT_OFFSET_X = 1;
  localparam int STAT_DEVICE_RESET_FLAG = 0;
  // Init and reset flags are up after any reset
  localparam logic [7:0] STAT_RESET_VALUE = 8'h21;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int OSC_HZ = 4_000_000;
  localparam int PRESCALE_DIV = 32;
  localparam int TICK_NS = 8_000;
  // Tick period in system clocks, rounded down; 200 at 25 MHz
  localparam int TICK_CYCLES = (TICK_NS * (CLK_HZ / 1_000_000)) / 1_000;
  localparam int OFFSET_BLANK_MS = 1_500;
  localparam longint OFFSET_BLANK_CYCLES = longint'(OFFSET_BLANK_MS) * longint'(CLK_HZ) / 1_000;
  // Reset sequence tracker
  typedef enum logic [1:0]
  {
    SCSR_SEQ_IDLE = 2'b00,
    SCSR_SEQ_STEP1 = 2'b01,
    SCSR_SEQ_STEP2 = 2'b10
  } scsr_seq_e;
endpackage

// ===== src/scsr_tick_counter.sv
`timescale 1ns/10ps
module scsr_tick_counter
  import scsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic soft_reset,
  output logic [7:0] count_value
);
  import scsr_pkg::*;

  logic [7:0] pre_reg;
  logic [7:0] pre_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;

  ////////////////////////////////////////////////////////////////
  // Prescaler stands in for the divide-by-32 of a 4 MHz oscillator
  always_comb
  begin
    pre_next = pre_reg;
    count_next = count_reg;
    if (soft_reset)
    begin
      pre_next = 8'h00;
      count_next = 8'h00;
    end
    else if (pre_reg == 8'(TICK_CYCLES - 1))
    begin
      pre_next = 8'h00;
      count_next = count_reg + 8'h01;
    end
    else
    begin
      pre_next = pre_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_reg <= 8'h00;
      count_reg <= 8'h00;
    end
    else
    begin
      pre_reg <= pre_next;
      count_reg <= count_next;
    end
  end

  assign count_value = count_reg;
endmodule

// ===== src/scsr_reset_seq.sv
`timescale 1ns/10ps
module scsr_reset_seq
  import scsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ctl_write,
  input wire logic seq_upper,
  input wire logic seq_lower,
  output logic soft_reset
);
  import scsr_pkg::*;

  scsr_seq_e state_reg;
  scsr_seq_e state_next;
  logic fire_reg;
  logic fire_next;

  ////////////////////////////////////////////////////////////////
  // Tracks only the two sequence bits; other bits never matter
  always_comb
  begin
    state_next = state_reg;
    fire_next = 1'b0;
    if (ctl_write)
    begin
      unique case (state_reg)
        SCSR_SEQ_IDLE:
        begin
          if (seq_upper && !seq_lower)
            state_next = SCSR_SEQ_STEP1;
        end
        SCSR_SEQ_STEP1:
        begin
          if (seq_upper && seq_lower)
            state_next = SCSR_SEQ_STEP2;
          else if (!seq_upper && !seq_lower)
            state_next = SCSR_SEQ_IDLE;
        end
        SCSR_SEQ_STEP2:
        begin
          if (!seq_upper && seq_lower)
          begin
            state_next = SCSR_SEQ_IDLE;
            fire_next = 1'b1;
          end
          else if (!seq_upper && !seq_lower)
            state_next = SCSR_SEQ_IDLE;
        end
        default:
          state_next = SCSR_SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= SCSR_SEQ_IDLE;
      fire_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      fire_reg <= fire_next;
    end
  end

  assign soft_reset = fire_reg;
endmodule

// ===== verification/scsr_regs_monitor.sv
`timescale 1ns/10ps
module scsr_regs_monitor
  import scsr_pkg::*;
#(
  parameter longint OFFSET_BLANK = 50
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_request_error,
  input wire logic test_mode,
  input wire logic chip_select_n,
  input wire logic osc_force_dout_high,
  input wire logic filter_bypass,
  input wire logic self_test_enable,
  input wire logic self_test_direction,
  input wire logic y_invert_active,
  input wire logic soft_reset
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  wire ctl_wr = reg_write && reg_addr == ADDR_DEVICE_CONTROL;
  logic [7:0] wd_q;
  // Write data one cycle back, for the apply checks
  always_ff @(posedge sys_clk)
    wd_q <= reg_wdata;
  ////////////////////////////////////////////////////////////
  err_write_a: assert property (reg_request_error == (reg_write && !ctl_wr))
    else $error("request error flag wrong");
  seq_end_a: assert property (soft_reset |-> $past(ctl_wr) && $past(reg_wdata[7:6]) == 2'b01)
    else $error("soft reset without third write");
  pulse_one_a: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset pulse too long");
  ctl_clear_a: assert property (soft_reset |=> !self_test_enable && !self_test_direction && !filter_bypass)
    else $error("control not cleared");
  // Writes that leave the sequence bits clear take effect next cycle
  ctl_apply_a: assert property (ctl_wr && reg_wdata[7:6] == 2'b00 && !soft_reset |=>
    self_test_enable == wd_q[0] && self_test_direction == wd_q[1] && filter_bypass == (wd_q[3] | wd_q[0]))
    else $error("control write not applied");
  y_inv_a: assert property (ctl_wr && reg_wdata[7:6] == 2'b00 && !soft_reset |=> y_invert_active == (wd_q[2] & wd_q[0]))
    else $error("y inversion wrong");
  osc_force_a: assert property (osc_force_dout_high |-> !chip_select_n && !test_mode)
    else $error("data out forced without select");
  ctl_read_a: assert property (reg_read && reg_addr == ADDR_DEVICE_CONTROL |=> (reg_rdata & ~CTL_READ_MASK) == 8'h00)
    else $error("control read shows write-only bits");
  hpf_view_a: assert property (reg_read && reg_addr == ADDR_DEVICE_STATUS |=> reg_rdata[3] != $past(filter_bypass))
    else $error("filter present bit wrong");
  c_soft: cover property (soft_reset);
  c_err: cover property (reg_request_error);
  c_osc: cover property (osc_force_dout_high);
endmodule

// ===== verification/scsr_host_model.sv
`timescale 1ns/10ps
module scsr_host_model
  import scsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reg_request_error,
  output logic reg_write,
  output logic reg_read,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic chip_select_n
);
  initial
  begin
    {reg_write, reg_read, chip_select_n, reg_addr, reg_wdata} = 16'h2000;
  end
  ////////////////////////////////////////////////////////////
  // One transfer; released bus lines show the inverse, never stale data
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d, input int w, output logic err);
    repeat (w + 1) @(posedge sys_clk);
    reg_write <= wr;
    reg_read <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    chip_select_n <= 1'b0;
    @(posedge sys_clk);
    // Request error answers in the strobe cycle; taken at the edge that ends it
    err = reg_request_error;
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    chip_select_n <= 1'b1;
  endtask
  task automatic reset_seq(input logic [5:0] lo);
    logic e;
    xfer(1'b1, ADDR_DEVICE_CONTROL, {2'b10, lo}, 0, e);
    xfer(1'b1, ADDR_DEVICE_CONTROL, {2'b11, lo}, 0, e);
    xfer(1'b1, ADDR_DEVICE_CONTROL, {2'b01, lo}, 0, e);
  endtask
endmodule

// ===== verification/sensor_control_status_regs_tb_top.sv
`timescale 1ns/10ps
module sensor_control_status_regs_tb_top;
  import scsr_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic init_done, test_mode, parity_fault, fuse_parity_fault, marginal_fuse, osc_mismatch;
  logic temp_limit, offset_limit_x, offset_limit_y, chip_select_n, reg_write, reg_read;
  logic reg_request_error, osc_force_dout_high, filter_bypass, filter_freeze, self_test_enable;
  logic self_test_direction, y_invert_active, accel_data_allowed, soft_reset, e;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, temp_sample, ctl, st, v, c0, d;
  logic [4:0] bad [4] = '{ADDR_TEMPERATURE_VALUE, ADDR_DEVICE_STATUS, ADDR_TICK_COUNTER, 5'h0d};
  int miscompares = 0;
  int n_compared = 0;
  scsr_regs #(.OFFSET_BLANK(50)) scsr_regs_i (.*);
  scsr_host_model scsr_host_model_i (.*);
  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////
  task automatic chk8(input string n, input logic [7:0] x, input logic [7:0] g);
    n_compared++;
    if (g !== x)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rd(input logic [4:0] a);
    scsr_host_model_i.xfer(1'b0, a, 8'h00, $urandom_range(2), e);
    #1;
    v = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] dw);
    scsr_host_model_i.xfer(1'b1, ADDR_DEVICE_CONTROL, dw, $urandom_range(2), e);
    ctl = dw & CTL_READ_MASK;
    chk8("request error", 8'h00, {7'h0, e});
  endtask
  // Status view: filter present unless bypassed or in self-test
  function automatic logic [7:0] exp_st();
    return st | {4'h0, !(ctl[3] | ctl[0]), 3'h0};
  endfunction
  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard, well past the thousand-odd cycles the run needs
  initial
  begin
    #400_000;
    miscompares++;
    test_done();
  end
  initial
  begin
    {init_done, test_mode, parity_fault, fuse_parity_fault, marginal_fuse, osc_mismatch} = '0;
    {temp_limit, offset_limit_x, offset_limit_y, temp_sample} = '0;
    void'($urandom(55526));
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    {st, ctl} = 16'h2100;
    rd(ADDR_DEVICE_CONTROL);
    chk8("control", 8'h00, v);
    rd(ADDR_DEVICE_STATUS);
    chk8("status", exp_st(), v);
    // Clear-error too early must keep the reset flag
    wr(8'h20);
    rd(ADDR_DEVICE_STATUS);
    chk8("status", exp_st(), v);
    @(posedge sys_clk);
    init_done <= 1'b1;
    @(posedge sys_clk);
    init_done <= 1'b0;
    st = 8'h01;
    rd(ADDR_DEVICE_STATUS);
    chk8("status", exp_st(), v);
    wr(8'h20);
    st = 8'h00;
    rd(ADDR_DEVICE_STATUS);
    chk8("status", exp_st(), v);
    chk8("data allowed", 8'h01, {7'h0, accel_data_allowed});
    // Self-test stays on for microseconds only, far under the limit
    for (int i = 0; i < 16; i++)
    begin
      d = (i == 0) ? 8'h3f : 8'($urandom) & 8'h3f;
      wr(d);
      rd(ADDR_DEVICE_CONTROL);
      chk8("control", d & CTL_READ_MASK, v);
      chk8("self test", {5'h0, d[2] & d[0], d[1], d[0]}, {5'h0, y_invert_active, self_test_direction, self_test_enable});
      chk8("filter out", {6'h0, {2{d[3] | d[0]}}}, {6'h0, filter_bypass, filter_freeze});
      rd(ADDR_DEVICE_STATUS);
      chk8("status", exp_st(), v);
    end
    for (int i = 0; i < 5; i++)
    begin
      scsr_host_model_i.xfer(1'b1, (i < 4) ? bad[i] : 5'($urandom_range(18, 31)), 8'h0f, 0, e);
      chk8("request error", 8'h01, {7'h0, e});
    end
    rd(ADDR_DEVICE_CONTROL);
    chk8("control", ctl, v);
    @(posedge sys_clk);
    temp_sample <= 8'($urandom);
    repeat (3) @(posedge sys_clk);
    rd(ADDR_TEMPERATURE_VALUE);
    chk8("temperature", temp_sample, v);
    // Faults: clear-error while the temperature limit still holds
    @(posedge sys_clk);
    temp_limit <= 1'b1;
    offset_limit_x <= 1'b1;
    @(posedge sys_clk);
    offset_limit_x <= 1'b0;
    wr(8'h00);
    st = 8'h12;
    rd(ADDR_DEVICE_STATUS);
    chk8("status", exp_st(), v);
    wr(8'h20);
    st = 8'h10;
    rd(ADDR_DEVICE_STATUS);
    chk8("status", exp_st(), v);
    chk8("data allowed", 8'h00, {7'h0, accel_data_allowed});
    @(posedge sys_clk);
    temp_limit <= 1'b0;
    wr(8'h20);
    st = 8'h00;
    rd(ADDR_DEVICE_STATUS);
    chk8("status", exp_st(), v);
    chk8("data allowed", 8'h01, {7'h0, accel_data_allowed});
    // Aborted sequence leaves the device running
    wr(8'h85);
    wr(8'h05);
    wr(8'hc5);
    wr(8'h45);
    rd(ADDR_DEVICE_CONTROL);
    chk8("control", 8'h05, v);
    @(posedge sys_clk);
    parity_fault <= 1'b1;
    @(posedge sys_clk);
    parity_fault <= 1'b0;
    wr(8'h20);
    st = 8'h80;
    rd(ADDR_DEVICE_STATUS);
    chk8("status", exp_st(), v);
    scsr_host_model_i.reset_seq(6'h0b);
    {st, ctl} = 16'h2100;
    @(posedge sys_clk);
    offset_limit_y <= 1'b1;
    @(posedge sys_clk);
    offset_limit_y <= 1'b0;
    rd(ADDR_DEVICE_CONTROL);
    chk8("control", 8'h00, v);
    rd(ADDR_DEVICE_STATUS);
    chk8("status", exp_st(), v);
    // Reads 1000 cycles apart span exactly five ticks
    scsr_host_model_i.xfer(1'b0, ADDR_TICK_COUNTER, 8'h00, 0, e);
    #1;
    c0 = reg_rdata;
    repeat (998) @(posedge sys_clk);
    scsr_host_model_i.xfer(1'b0, ADDR_TICK_COUNTER, 8'h00, 0, e);
    #1;
    chk8("counter", c0 + 8'h05, reg_rdata);
    @(posedge sys_clk);
    osc_mismatch <= 1'b1;
    repeat (4) @(posedge sys_clk);
    st = 8'h61;
    rd(ADDR_DEVICE_STATUS);
    chk8("status", exp_st(), v);
    // Data output forced only while selected, and never in test mode
    for (int m = 0; m < 2; m++)
    begin
      @(posedge sys_clk);
      test_mode <= m[0];
      fork
        rd(ADDR_DEVICE_STATUS);
        begin
          @(negedge chip_select_n);
          #1;
          chk8("dout forced", {7'h0, !m[0]}, {7'h0, osc_force_dout_high});
        end
      join
      chk8("dout released", 8'h00, {7'h0, osc_force_dout_high});
    end
    test_done();
  end
endmodule
bind scsr_regs scsr_regs_monitor #(.OFFSET_BLANK(OFFSET_BLANK)) scsr_regs_monitor_i (.sys_clk, .resetn, .reg_write,
  .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .reg_request_error, .test_mode, .chip_select_n, .osc_force_dout_high,
  .filter_bypass, .self_test_enable, .self_test_direction, .y_invert_active, .soft_reset);
